// ---- logic/ncr_alu.sv ----
// Four-bit arithmetic and logic unit of the core
`timescale 1ns/100ps
module ncr_alu
  import ncr_pkg::*;
(
  input  wire ncr_op_e        op,     // Operation
  input  wire logic [DW-1:0]  acc,    // Accumulator operand
  input  wire logic [DW-1:0]  mem,    // RAM operand
  input  wire logic [DW-1:0]  imm,    // Immediate operand
  input  wire logic [1:0]     bsel,   // Bit select
  input  wire logic           cy_in,  // Carry in
  output logic [DW-1:0]       res,    // Result nibble
  output logic                cout,   // Carry out of the sum
  output logic                cond    // Skip condition
);

  function automatic logic [DW-1:0] bit_mask(input logic [1:0] s);
    bit_mask = DW'(1) << s;
  endfunction

  logic [DW:0] sum;

  always_comb
  begin
    sum  = '0;
    res  = acc;
    cout = 1'b0;
    cond = 1'b0;
    case (op)
      OP_ADD_IMM:   sum = {1'b0, acc} + {1'b0, imm};
      OP_ADD_MEM:   sum = {1'b0, acc} + {1'b0, mem};
      OP_ADD_MEM_C: sum = {1'b0, acc} + {1'b0, mem} + {4'h0, cy_in};
      OP_AND_MEM:   res = acc & mem;
      OP_OR_MEM:    res = acc | mem;
      OP_CMP_MEM:   cond = (acc == mem);
      OP_SET_BIT:   res = mem | bit_mask(bsel);
      OP_CLR_BIT:   res = mem & ~bit_mask(bsel);
      OP_TEST_BIT:  cond = ((mem & bit_mask(bsel)) == '0);
      OP_ROT_R:     res = {cy_in, acc[DW-1:1]};
      default:      res = acc;
    endcase
    if (op == OP_ADD_IMM || op == OP_ADD_MEM || op == OP_ADD_MEM_C)
    begin
      res  = sum[DW-1:0];
      cout = sum[DW];
    end
  end

endmodule

// ---- logic/ncr_core.sv ----
// Register and sequencing datapath of the nibble CPU core
//
// Function
// - ALU does 4-bit add, compare, AND, OR, bits
// - Accumulator is the 4-bit working register
// - Carry-add sets carry flag on carry out
// - Plain adds leave the carry flag alone
// - Rotate right moves accumulator bit 0 to carry
// - Set and clear carry operations force the flag
// - Transfer register pairs temporary high, accumulator low
// - Pointer plus accumulator form in-page ROM address
// - Upper table mode loads ROM top bits
// - Without upper table mode pointer stays unchanged
// - Upper table flag set, cleared, zero at reset
// - Eight stack entries saved on call, interrupt, table
// - Depth pointer tracks nesting, copies to accumulator
// - Interrupt entry saves data pointer, carry, skip, accumulator, temporary
// - Only interrupt entry writes the context save
// - Skip flag steers skips, kept across interrupts
// - Counter advances by length or loads targets
// - Counter splits into page and in-page offset
// - Offset 127 rolls to next page start
// - Machine cycle equals three system clocks
// - Pages hold 128 words, offset is 7 bits
`timescale 1ns/100ps
module ncr_core
  import ncr_pkg::*;
(
  input  wire logic            ref_clk,   // System clock, 250 MHz
  input  wire logic            rst,       // Sync reset, active high
  input  wire logic            ce,        // Clock enable, freezes state
  input  wire ncr_instr_s      instr,     // Decoded instruction
  input  wire logic [DW-1:0]   mem_data,  // RAM word at data pointer
  input  wire logic [DW-1:0]   port_in,   // Port input nibble
  input  wire logic [RW-1:0]   rom_word,  // Program word at rom_addr
  output logic [1:0]           mc_phase,  // Phase within machine cycle
  output logic [PCW-1:0]       pc,        // Program counter
  output logic [PGW-1:0]       pc_page,   // Page select part of pc
  output logic [OFSW-1:0]      pc_ofs,    // In-page offset part of pc
  output logic [DW-1:0]        acc,       // Accumulator
  output logic [DW-1:0]        tmp_b,     // Temporary register
  output logic [EW-1:0]        xfer_e,    // Transfer register
  output logic [PW-1:0]        tbl_ptr,   // Table pointer register
  output logic [DPW-1:0]       dptr,      // Data pointer
  output logic                 carry,     // Carry flag
  output logic                 skip,      // Skip flag
  output logic                 upper_table_bits_flag,      // Upper table bits flag
  output logic [SPW-1:0]       stk_lvl,   // Stack depth pointer
  output logic [PCW-1:0]       rom_addr,  // Table lookup address
  output logic                 ram_we,    // RAM write pulse
  output logic [DW-1:0]        ram_wdata, // RAM write data
  output logic                 port_we,   // Port write pulse
  output logic [DW-1:0]        port_out   // Port output nibble
);

  ncr_core_s      q;
  ncr_core_s      n;
  logic           last;
  logic           go;
  logic [PCW-1:0] pc_seq;
  logic [PCW-1:0] regs_tgt;
  logic [DW-1:0]  alu_res;
  logic           alu_cout;
  logic           alu_cond;
  logic           st_push;
  logic           st_pop;
  logic           st_save;
  logic [PCW-1:0] st_wdata;
  logic [PCW-1:0] st_top;
  logic [SPW-1:0] st_sp;

  ncr_alu u_alu (
    .op    (instr.op),
    .acc   (q.acc),
    .mem   (mem_data),
    .imm   (instr.imm[DW-1:0]),
    .bsel  (instr.bsel),
    .cy_in (q.cy),
    .res   (alu_res),
    .cout  (alu_cout),
    .cond  (alu_cond)
  );

  ncr_stack u_stack (
    .ref_clk (ref_clk),
    .rst     (rst),
    .ce      (ce),
    .push    (st_push),
    .pop     (st_pop),
    .save    (st_save),
    .wdata   (st_wdata),
    .top     (st_top),
    .sp      (st_sp)
  );

  // Instructions execute only on the last clock of a machine cycle; the table lookup address loads on every clock of a table op
  assign last = (q.phase == PH_LAST);
  // A pending skip turns any instruction but interrupt entry into a no-op
  assign go   = last && !(q.skip && instr.op != OP_INT_ENTRY);
  // Plain add: in-page offset overflows into page select
  assign pc_seq   = q.pc + PCW'(instr.len);
  assign regs_tgt = {instr.imm[PGW-1:0], q.d, q.acc};

  always_comb
  begin
    n        = q;
    n.ram_we  = 1'b0;
    n.port_we = 1'b0;
    st_push  = 1'b0;
    st_pop   = 1'b0;
    st_save  = 1'b0;
    st_wdata = pc_seq;
    n.phase  = last ? 2'h0 : q.phase + 2'h1;
    if (instr.op == OP_TABLE)
      n.rom_addr = regs_tgt;
    if (last)
    begin
      n.pc = pc_seq;
      if (!go)
        n.skip = 1'b0;
    end
    if (go)
    begin
      case (instr.op)
        OP_ADD_IMM, OP_ADD_MEM:
          n.acc = alu_res;
        OP_ADD_MEM_C:
        begin
          n.acc = alu_res;
          n.cy  = alu_cout;
        end
        OP_AND_MEM, OP_OR_MEM:
          n.acc = alu_res;
        OP_CMP_MEM, OP_TEST_BIT:
          n.skip = alu_cond;
        OP_SET_BIT, OP_CLR_BIT:
        begin
          n.ram_we    = 1'b1;
          n.ram_wdata = alu_res;
        end
        OP_STORE_A:
        begin
          n.ram_we    = 1'b1;
          n.ram_wdata = q.acc;
        end
        OP_ROT_R:
        begin
          n.acc = alu_res;
          n.cy  = q.acc[0];
        end
        OP_SET_C:
          n.cy = 1'b1;
        OP_CLR_C:
          n.cy = 1'b0;
        OP_LD_A_IMM:
          n.acc = instr.imm[DW-1:0];
        OP_XCH_AB:
        begin
          n.acc = q.b;
          n.b   = q.acc;
        end
        OP_BA_TO_E:
          n.e = {q.b, q.acc};
        OP_E_TO_BA:
        begin
          n.b   = q.e[EW-1:DW];
          n.acc = q.e[DW-1:0];
        end
        OP_LD_DP:
          n.dp = instr.imm;
        OP_PORT_IN:
          n.acc = port_in;
        OP_PORT_OUT:
        begin
          n.port_we  = 1'b1;
          n.port_out = q.acc;
        end
        OP_TABLE:
        begin
          // Return address lands in the current entry; the depth pointer does not move
          st_save = 1'b1;
          n.acc   = rom_word[DW-1:0];
          n.b     = rom_word[2*DW-1:DW];
          if (q.upper_table_bits_flag)
            n.d = {1'b0, rom_word[TBL_HI:TBL_LO]};
        end
        OP_JMP_REGS:
          n.pc = {q.pc[PCW-1:OFSW], q.d, q.acc};
        OP_CALL_REGS:
        begin
          st_push = 1'b1;
          n.pc    = regs_tgt;
        end
        OP_JMP:
          n.pc = instr.tgt;
        OP_CALL:
        begin
          st_push = 1'b1;
          n.pc    = instr.tgt;
        end
        OP_RET, OP_RET_SKIP:
        begin
          st_pop = 1'b1;
          n.pc   = st_top;
          n.skip = (instr.op == OP_RET_SKIP);
        end
        OP_SET_UPT:
          n.upper_table_bits_flag = 1'b1;
        OP_CLR_UPT:
          n.upper_table_bits_flag = 1'b0;
        OP_SP_TO_A:
          n.acc = {1'b0, st_sp};
        OP_INT_ENTRY:
        begin
          st_push  = 1'b1;
          st_wdata = q.pc;
          n.ctx    = '{dp: q.dp, cy: q.cy, skip: q.skip,
                       acc: q.acc, b: q.b};
          n.skip   = 1'b0;
          n.pc     = instr.tgt;
        end
        OP_INT_RET:
        begin
          st_pop = 1'b1;
          n.pc   = st_top;
          n.dp   = q.ctx.dp;
          n.cy   = q.ctx.cy;
          n.skip = q.ctx.skip;
          n.acc  = q.ctx.acc;
          n.b    = q.ctx.b;
        end
        default:
          n.pc = pc_seq;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      q <= CORE_RST;
    else if (ce)
      q <= n;
  end

  assign mc_phase  = q.phase;
  assign pc        = q.pc;
  assign pc_page   = q.pc[PCW-1:OFSW];
  assign pc_ofs    = q.pc[OFSW-1:0];
  assign acc       = q.acc;
  assign tmp_b     = q.b;
  assign xfer_e    = q.e;
  assign tbl_ptr   = q.d;
  assign dptr      = q.dp;
  assign carry     = q.cy;
  assign skip      = q.skip;
  assign upper_table_bits_flag      = q.upper_table_bits_flag;
  assign stk_lvl   = st_sp;
  assign rom_addr  = q.rom_addr;
  assign ram_we    = q.ram_we;
  assign ram_wdata = q.ram_wdata;
  assign port_we   = q.port_we;
  assign port_out  = q.port_out;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst || !ce);

  sequence s_two_idle;
    !last ##1 !last;
  endsequence

  property p_mc_len;
    last |=> s_two_idle ##1 last;
  endproperty
  a_mc_len: assert property (p_mc_len)
    else $error("machine cycle is not three clocks");

  property p_carry_add;
    go && instr.op == OP_ADD_MEM_C |=> q.cy == $past(alu_cout);
  endproperty
  a_carry_add: assert property (p_carry_add)
    else $error("carry-add did not load carry out");

  property p_add_keeps_cy;
    go && (instr.op == OP_ADD_IMM || instr.op == OP_ADD_MEM)
      |=> $stable(q.cy);
  endproperty
  a_add_keeps_cy: assert property (p_add_keeps_cy)
    else $error("plain add changed carry");

  property p_rot_cy;
    go && instr.op == OP_ROT_R |=> q.cy == $past(q.acc[0]);
  endproperty
  a_rot_cy: assert property (p_rot_cy)
    else $error("rotate did not move bit 0 to carry");

  property p_set_clr_cy;
    go && (instr.op == OP_SET_C || instr.op == OP_CLR_C)
      |=> q.cy == ($past(instr.op) == OP_SET_C);
  endproperty
  a_set_clr_cy: assert property (p_set_clr_cy)
    else $error("carry not forced by set or clear");

  property p_tbl_upper;
    go && instr.op == OP_TABLE && q.upper_table_bits_flag
      |=> q.d == {1'b0, $past(rom_word[TBL_HI:TBL_LO])};
  endproperty
  a_tbl_upper: assert property (p_tbl_upper)
    else $error("pointer not loaded from table top bits");

  property p_tbl_keep;
    go && instr.op == OP_TABLE && !q.upper_table_bits_flag |=> $stable(q.d);
  endproperty
  a_tbl_keep: assert property (p_tbl_keep)
    else $error("pointer changed outside upper table mode");

  property p_sp_to_a;
    go && instr.op == OP_SP_TO_A |=> q.acc == {1'b0, $past(st_sp)};
  endproperty
  a_sp_to_a: assert property (p_sp_to_a)
    else $error("depth pointer not copied to accumulator");

  property p_ctx_only_int;
    !(go && instr.op == OP_INT_ENTRY) |=> $stable(q.ctx);
  endproperty
  a_ctx_only_int: assert property (p_ctx_only_int)
    else $error("context save written outside interrupt entry");

  property p_page_roll;
    go && instr.op == OP_NOP && instr.len == 2'h1
      && q.pc[OFSW-1:0] == OFSW'(PAGE_WORDS - 1)
      |=> q.pc[OFSW-1:0] == '0
          && q.pc[PCW-1:OFSW] == $past(q.pc[PCW-1:OFSW]) + PGW'(1);
  endproperty
  a_page_roll: assert property (p_page_roll)
    else $error("last offset did not roll to next page");

endmodule

// ---- logic/ncr_pkg.sv ----
// Shared constants and types for the nibble CPU core registers
package ncr_pkg;

  localparam int DW      = 4;   // Data nibble width
  localparam int EW      = 8;   // Transfer register width
  localparam int PW      = 3;   // Table pointer width
  localparam int OFSW    = 7;   // In-page offset width
  localparam int PAGE_WORDS = 128;
  localparam int PGW     = 5;   // Page select width
  localparam int PCW     = PGW + OFSW;
  localparam int RW      = 10;  // Program word width
  localparam int SPW     = 3;   // Stack pointer width
  localparam int SDEPTH  = 8;   // Return stack levels
  localparam int DPW     = 8;   // Data pointer width
  localparam int IMMW    = 8;
  localparam int CLK_DIV = 3;   // System clocks per machine cycle
  localparam logic [1:0] PH_LAST = 2'(CLK_DIV - 1);
  localparam int TBL_HI  = RW - 1;  // Upper table bits of a program word
  localparam int TBL_LO  = RW - 2;

  typedef enum logic [5:0] {
    OP_NOP, OP_ADD_IMM, OP_ADD_MEM, OP_ADD_MEM_C, OP_AND_MEM, OP_OR_MEM,
    OP_CMP_MEM, OP_SET_BIT, OP_CLR_BIT, OP_TEST_BIT, OP_ROT_R, OP_SET_C,
    OP_CLR_C, OP_LD_A_IMM, OP_XCH_AB, OP_BA_TO_E, OP_E_TO_BA, OP_LD_DP,
    OP_PORT_IN, OP_PORT_OUT, OP_STORE_A, OP_TABLE, OP_JMP_REGS,
    OP_CALL_REGS, OP_JMP, OP_CALL, OP_RET, OP_RET_SKIP, OP_SET_UPT,
    OP_CLR_UPT, OP_SP_TO_A, OP_INT_ENTRY, OP_INT_RET
  } ncr_op_e;

  typedef struct packed {
    ncr_op_e           op;
    logic [IMMW-1:0]   imm;   // Immediate, page in low bits for table ops
    logic [1:0]        bsel;  // Bit select
    logic [1:0]        len;   // Instruction length in words
    logic [PCW-1:0]    tgt;   // Branch, call or vector target
  } ncr_instr_s;

  typedef struct packed {
    logic [DPW-1:0] dp;
    logic           cy;
    logic           skip;
    logic [DW-1:0]  acc;
    logic [DW-1:0]  b;
  } ncr_ctx_s;

  typedef struct packed {
    logic [1:0]     phase;
    logic [PCW-1:0] pc;
    logic [DW-1:0]  acc;
    logic [DW-1:0]  b;
    logic [EW-1:0]  e;
    logic [PW-1:0]  d;
    logic [DPW-1:0] dp;
    logic           cy;
    logic           skip;
    logic           upper_table_bits_flag;
    ncr_ctx_s       ctx;
    logic [PCW-1:0] rom_addr;
    logic           ram_we;
    logic [DW-1:0]  ram_wdata;
    logic           port_we;
    logic [DW-1:0]  port_out;
  } ncr_core_s;

  typedef struct packed {
    logic [SPW-1:0]                sp;
    logic [SDEPTH-1:0][PCW-1:0]    ent;
  } ncr_stack_s;

  localparam ncr_core_s  CORE_RST  = '0;
  localparam ncr_stack_s STACK_RST = '0;

endpackage

// ---- logic/ncr_stack.sv ----
// Eight-level return stack with its depth pointer
`timescale 1ns/100ps
module ncr_stack
  import ncr_pkg::*;
(
  input  wire logic            ref_clk, // System clock
  input  wire logic            rst,     // Sync reset, active high
  input  wire logic            ce,      // Clock enable
  input  wire logic            push,    // Store and go one level deeper
  input  wire logic            pop,     // Go one level back
  input  wire logic            save,    // Store at current level, no move
  input  wire logic [PCW-1:0]  wdata,   // Address to store
  output logic [PCW-1:0]       top,     // Address at the level below sp
  output logic [SPW-1:0]       sp       // Current nesting level
);

  ncr_stack_s q;
  ncr_stack_s n;

  // Overflow simply wraps the pointer and overwrites the oldest entry
  always_comb
  begin
    n = q;
    if (push || save)
      n.ent[q.sp] = wdata;
    if (push)
      n.sp = q.sp + SPW'(1);
    else if (pop)
      n.sp = q.sp - SPW'(1);
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      q <= STACK_RST;
    else if (ce)
      q <= n;
  end

  assign top = q.ent[q.sp - SPW'(1)];
  assign sp  = q.sp;

endmodule

// ---- test/ncr_far_model.sv ----
// Far-side model: program ROM and data RAM seen by the core
`timescale 1ns/100ps
module ncr_far_model
  import ncr_pkg::*;
(
  input  wire logic [0:0]     ref_clk,   // System clock
  input  wire logic [PCW-1:0] rom_addr,  // Table lookup address
  output logic      [RW-1:0]  rom_word,  // Registered ROM word
  input  wire logic [DPW-1:0] dptr,      // RAM address
  output logic      [DW-1:0]  mem_data,  // RAM word at dptr
  input  wire logic           ram_we,    // RAM write pulse
  input  wire logic [DW-1:0]  ram_wdata  // RAM write data
);
  logic [DW-1:0] ram [2**DPW];

  initial
  begin
    for (int i = 0; i < 2**DPW; i++)
      ram[i] = 4'(i) ^ 4'ha;
  end

  // One clock of latency, as slow as a synchronous ROM macro may answer
  always @(posedge ref_clk)
    rom_word <= {rom_addr[1:0], rom_addr[11:4]} ^ 10'h2b6;

  always @(posedge ref_clk)
    if (ram_we)
      ram[dptr] <= ram_wdata;

  assign mem_data = ram[dptr];
endmodule

// ---- test/nibble_cpu_core_registers_tb.sv ----
// Self-checking bench of the nibble CPU core registers
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  err_count++; $display("wrong value at %0t: got %h expected %h", \
  $time, g, e); end end
module nibble_cpu_core_registers_tb
  import ncr_pkg::*;
  ();
  logic             ref_clk = 1'b0;
  logic             rst, ce, carry, skip, upper_table_bits_flag, ram_we, port_we;
  ncr_instr_s       instr;
  logic [DW-1:0]    mem_data, port_in, acc, tmp_b, ram_wdata, port_out;
  logic [RW-1:0]    rom_word, w;
  logic [1:0]       mc_phase;
  logic [PCW-1:0]   pc, rom_addr, p;
  logic [PGW-1:0]   pc_page;
  logic [OFSW-1:0]  pc_ofs;
  logic [EW-1:0]    xfer_e;
  logic [PW-1:0]    tbl_ptr, d;
  logic [DPW-1:0]   dptr;
  logic [SPW-1:0]   stk_lvl;
  logic [7:0]       r = 8'h16;
  logic [DW-1:0]    a, n, x;
  logic [DW:0]      s;
  logic [PCW-1:0]   rets [8];
  int               err_count = 0;
  int               samples_checked = 0;
  int               cyc = 0;

  always #2 ref_clk = ~ref_clk;

  ncr_core dut (.ref_clk, .rst, .ce, .instr, .mem_data, .port_in, .rom_word,
    .mc_phase, .pc, .pc_page, .pc_ofs, .acc, .tmp_b, .xfer_e, .tbl_ptr,
    .dptr, .carry, .skip, .upper_table_bits_flag, .stk_lvl, .rom_addr, .ram_we, .ram_wdata,
    .port_we, .port_out);

  ncr_far_model fm (.ref_clk, .rom_addr, .rom_word, .dptr, .mem_data,
    .ram_we, .ram_wdata);

  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  // Same pattern as the far-side ROM, kept separate on purpose
  function automatic logic [RW-1:0] romf(input logic [PCW-1:0] ad);
    return {ad[1:0], ad[11:4]} ^ 10'h2b6;
  endfunction

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // One machine cycle: present at phase 0, return just after execution
  task automatic run(input ncr_op_e o, input logic [7:0] i = 8'h00,
                     input logic [PCW-1:0] t = '0,
                     input logic [1:0] l = 2'h1,
                     input logic [1:0] b = 2'h0);
    int k;
    k = 0;
    while (mc_phase !== 2'h0 && k < 9)
    begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    instr = '{op: o, imm: i, bsel: b, len: l, tgt: t};
    @(posedge ref_clk);
    #1;
    `CHK(mc_phase, 2'h1)
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      err_count++;
      end_of_test();
    end
  end

  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    port_in = 4'h0;
    instr = '{OP_NOP, 8'h00, 2'h0, 2'h1, 12'h000};
    repeat (6) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    `CHK(pc, 12'h000)
    `CHK(upper_table_bits_flag, 1'b0)
    `CHK(stk_lvl, 3'h0)
    for (int k = 0; k < 16; k++)
    begin
      r = lfsr(r);
      a = r[3:0];
      n = r[7:4];
      run(OP_LD_DP, r);
      run(OP_LD_A_IMM, {4'h0, n});
      run(OP_STORE_A);
      `CHK({ram_we, ram_wdata}, {1'b1, n})
      run(k[0] ? OP_SET_C : OP_CLR_C);
      `CHK(carry, k[0])
      run(OP_LD_A_IMM, {4'h0, a});
      run(OP_ADD_IMM, {4'h0, n});
      `CHK({carry, acc}, {k[0], 4'(a + n)})
      run(OP_ADD_MEM);
      x = 4'(a + n + n);
      `CHK({carry, acc}, {k[0], x})
      run(OP_ADD_MEM_C);
      s = {1'b0, x} + {1'b0, n} + 5'(k[0]);
      `CHK({carry, acc}, s)
      run(OP_AND_MEM);
      `CHK(acc, s[3:0] & n)
      run(OP_LD_A_IMM, {4'h0, a});
      run(OP_OR_MEM);
      x = a | n;
      `CHK(acc, x)
      run(OP_ROT_R);
      `CHK({carry, acc}, {x[0], s[4], x[3:1]})
      port_in = a ^ n;
      run(OP_PORT_IN);
      run(OP_PORT_OUT);
      `CHK({port_we, port_out}, {1'b1, a ^ n})
      run(OP_LD_A_IMM, {4'h0, n});
      run(OP_CMP_MEM);
      `CHK(skip, 1'b1)
      p = pc;
      run(OP_ADD_IMM, 8'h01);
      `CHK({skip, acc, pc}, {1'b0, n, PCW'(p + 1)})
    end
    run(OP_LD_A_IMM, 8'h05);
    run(OP_XCH_AB);
    run(OP_LD_A_IMM, 8'h0c);
    run(OP_BA_TO_E);
    `CHK(xfer_e, 8'h5c)
    run(OP_XCH_AB);
    run(OP_E_TO_BA);
    `CHK({tmp_b, acc}, 8'h5c)
    run(OP_LD_A_IMM, 8'h06);
    run(OP_STORE_A);
    run(OP_SET_BIT, 8'h00, '0, 2'h1, 2'h3);
    `CHK({ram_we, ram_wdata}, 5'h1e)
    run(OP_CLR_BIT, 8'h00, '0, 2'h1, 2'h2);
    `CHK({ram_we, ram_wdata}, 5'h1a)
    run(OP_TEST_BIT, 8'h00, '0, 2'h1, 2'h2);
    `CHK(skip, 1'b1)
    // Skipped test must not set the flag again
    run(OP_TEST_BIT, 8'h00, '0, 2'h1, 2'h2);
    `CHK(skip, 1'b0)
    run(OP_TEST_BIT, 8'h00, '0, 2'h1, 2'h3);
    `CHK(skip, 1'b0)
    run(OP_LD_A_IMM, 8'h05);
    p = pc;
    run(OP_JMP_REGS);
    `CHK(pc, {p[11:7], 7'h05})
    run(OP_LD_A_IMM, 8'h03);
    p = pc;
    run(OP_CALL_REGS, 8'h06);
    `CHK({stk_lvl, pc}, {3'h1, 5'h06, 7'h03})
    run(OP_RET_SKIP);
    `CHK({stk_lvl, skip, pc}, {3'h0, 1'b1, PCW'(p + 1)})
    run(OP_LD_A_IMM, 8'h0f);
    `CHK({skip, acc}, 5'h03)
    run(OP_SET_UPT);
    `CHK(upper_table_bits_flag, 1'b1)
    // Pointer reset value is a design choice; lookups below set it anyway
    d = 3'h0;
    for (int j = 0; j < 3; j++)
    begin
      r = lfsr(r);
      run(OP_LD_A_IMM, r);
      p = pc;
      run(OP_TABLE, 8'h03);
      `CHK(rom_addr, {5'h03, d, r[3:0]})
      w = romf({5'h03, d, r[3:0]});
      `CHK({tmp_b, acc}, w[7:0])
      `CHK(tbl_ptr, {1'b0, w[9:8]})
      d = {1'b0, w[9:8]};
      `CHK({stk_lvl, pc}, {3'h0, PCW'(p + 1)})
    end
    run(OP_CLR_UPT);
    `CHK(upper_table_bits_flag, 1'b0)
    run(OP_LD_A_IMM, 8'h07);
    run(OP_TABLE, 8'h05);
    `CHK(tbl_ptr, d)
    // Seven levels deep keeps the return addresses intact
    for (int j = 0; j < 7; j++)
    begin
      rets[j] = PCW'(pc + 1);
      run(OP_CALL, 8'h00, {5'(j + 2), 7'h10});
      `CHK(pc, {5'(j + 2), 7'h10})
      `CHK(stk_lvl, 3'(j + 1))
    end
    run(OP_SP_TO_A);
    `CHK(acc, 4'h7)
    for (int j = 6; j >= 0; j--)
    begin
      run(OP_RET);
      `CHK({stk_lvl, pc}, {3'(j), rets[j]})
    end
    run(OP_LD_A_IMM, 8'h06);
    run(OP_XCH_AB);
    run(OP_LD_DP, 8'h3c);
    run(OP_LD_A_IMM, 8'h09);
    run(OP_STORE_A);
    run(OP_SET_C);
    run(OP_CMP_MEM);
    p = pc;
    run(OP_INT_ENTRY, 8'h00, 12'h080);
    `CHK({pc, skip, stk_lvl}, {12'h080, 1'b0, 3'h1})
    run(OP_LD_DP, 8'h00);
    run(OP_CLR_C);
    run(OP_CALL, 8'h00, 12'h200);
    run(OP_TABLE, 8'h01);
    run(OP_RET);
    run(OP_XCH_AB);
    run(OP_INT_RET);
    `CHK(pc, p)
    `CHK({dptr, carry, skip, acc, tmp_b}, 18'h0f396)
    run(OP_NOP);
    run(OP_JMP, 8'h00, {5'h03, 7'h7e});
    run(OP_NOP, 8'h00, '0, 2'h2);
    `CHK({pc_page, pc_ofs}, {5'h04, 7'h00})
    run(OP_JMP, 8'h00, {5'h04, 7'h7f});
    run(OP_NOP);
    `CHK(pc, {5'h05, 7'h00})
    // Reset in mid-run while the flag and counter are nonzero
    run(OP_SET_UPT);
    rst = 1'b1;
    @(posedge ref_clk);
    #1;
    rst = 1'b0;
    `CHK({upper_table_bits_flag, stk_lvl, pc, mc_phase}, 18'h00000)
    x = acc;
    instr = '{OP_ADD_IMM, 8'h01, 2'h0, 2'h1, 12'h000};
    @(posedge ref_clk);
    #1;
    ce = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
    `CHK({mc_phase, acc}, {2'h1, x})
    ce = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK(acc, 4'(x + 1))
    end_of_test();
  end
endmodule
